// ==== pcei_top.sv ====
`timescale 1ns/100ps
// Contract
// - ports of 8, 8, 8 and 2 pins
// - per input level or edge trigger select
// - high then low sample sets flag
// - enabled request wakes idle or powered-down core
// - each pin but the reset and serial pins picks one of four types
// - two config registers per port choose type
// - reset-shared pin always input only
// - serial pins only input-only or open-drain
// - quasi drives one weakly, zero strongly
// - open-drain pulls low only on zero
// - input-only leaves drivers off
// - push-pull drives one strongly high
// - analog disable bits cut port-0 inputs
// - analog disable bits clear on reset
// - all pins input-only after power-up
// - per-source enables plus global mask on requests, wake gated by per-source enables only
module pcei_top (
  input  wire logic                                 core_clk,
  input  wire logic                                 rst,
  input  wire logic [pcei_pkg::AW-1:0]              awaddr,
  input  wire logic                                 awvalid,
  output logic                                      awready,
  input  wire logic [31:0]                          wdata,
  input  wire logic [3:0]                           wstrb,
  input  wire logic                                 wvalid,
  output logic                                      wready,
  output logic [1:0]                                bresp,
  output logic                                      bvalid,
  input  wire logic                                 bready,
  input  wire logic [pcei_pkg::AW-1:0]              araddr,
  input  wire logic                                 arvalid,
  output logic                                      arready,
  output logic [31:0]                               rdata,
  output logic [1:0]                                rresp,
  output logic                                      rvalid,
  input  wire logic                                 rready,
  input  wire logic [pcei_pkg::NPINS-1:0]           padIn,
  output pcei_pkg::pcei_pad_t [pcei_pkg::NPINS-1:0] padDrive,
  input  wire logic                                 cpuIdle,
  input  wire logic                                 cpuPowerDown,
  input  wire logic [1:0]                           intAck,
  output logic [1:0]                                extIntReq,
  output logic                                      extWake
);
  localparam int N = pcei_pkg::NPINS;
  logic [N-1:0]        syncA;
  logic [N-1:0]        syncB;
  logic [N-1:0]        latch;
  logic [N-1:0]        cfg1;
  logic [N-1:0]        cfg2;
  logic [1:0]          trig;
  logic [1:0]          flag;
  logic [1:0]          intEn;
  logic [1:0]          intPrev;
  logic                globalEn;
  logic [5:1]          adis;
  logic                awHeld;
  logic                wHeld;
  logic [7:0]          awAddrQ;
  logic [31:0]         wDataQ;
  logic [3:0]          wStrbQ;
  pcei_pkg::pcei_pad_t [N-1:0] next_pad;
  wire  [1:0]          intLvl;
  wire  [1:0]          next_flag;
  wire  [3:0]          wrCtrl;
  wire  [3:0]          rdCtrl;
  wire  [3:0]          rdPin;
  wire  [31:0]         rdAcc [0:4];

  // bus handshakes
  wire awTake = awvalid && awready;
  wire wTake = wvalid && wready;
  wire arTake = arvalid && arready;
  wire wrFire = awHeld && wHeld && !bvalid;
  wire next_awHeld = (awHeld && !wrFire) || awTake;
  wire next_wHeld = (wHeld && !wrFire) || wTake;
  wire next_bvalid = wrFire || (bvalid && !bready);
  wire next_rvalid = arTake || (rvalid && !rready);

  wire wrTic = wrFire && awAddrQ == pcei_pkg::OFF_TICTL;
  wire wrIen = wrFire && awAddrQ == pcei_pkg::OFF_IEN;
  wire wrAdis = wrFire && awAddrQ == pcei_pkg::OFF_ADIS;
  wire wrPinRo = awAddrQ[7:4] == pcei_pkg::OFF_PIN0[7:4] && awAddrQ[1:0] == 2'h0;
  wire wrHit = (|wrCtrl) || wrPinRo || awAddrQ == pcei_pkg::OFF_TICTL ||
               awAddrQ == pcei_pkg::OFF_IEN || awAddrQ == pcei_pkg::OFF_ADIS;
  wire rdTic = araddr == pcei_pkg::OFF_TICTL;
  wire rdIen = araddr == pcei_pkg::OFF_IEN;
  wire rdAdis = araddr == pcei_pkg::OFF_ADIS;
  wire rdHit = (|rdCtrl) || (|rdPin) || rdTic || rdIen || rdAdis;

  wire [N-1:0] adisMask = {{(N - 6){1'b0}}, adis, 1'b0};
  wire [N-1:0] pinVal = syncB & ~adisMask;
  wire [31:0] latchPad = {{(32 - N){1'b0}}, latch};
  wire [31:0] cfg1Pad = {{(32 - N){1'b0}}, cfg1};
  wire [31:0] cfg2Pad = {{(32 - N){1'b0}}, cfg2};
  wire [31:0] pinPad = {{(32 - N){1'b0}}, pinVal};
  wire [31:0] ticWord = {28'h0000000, flag[1], trig[1], flag[0], trig[0]};
  wire [31:0] ienWord = {24'h000000, globalEn, 4'h0, intEn[1], 1'b0, intEn[0]};
  wire [31:0] adisWord = {26'h0000000, adis, 1'b0};

  assign rdAcc[0] = ({32{rdTic}} & ticWord) | ({32{rdIen}} & ienWord) | ({32{rdAdis}} & adisWord);

  // four ports, the last two bits wide
  // two config bytes per port word
  genvar p;
  generate
    for (p = 0; p < pcei_pkg::NPORTS; p++) begin : gPort
      localparam logic [7:0] CO = 8'(pcei_pkg::OFF_CTRL0 + 4 * p);
      localparam logic [7:0] PO = 8'(pcei_pkg::OFF_PIN0 + 4 * p);
      wire [31:0] ctrlWord = {8'h00, cfg2Pad[8*p+:8], cfg1Pad[8*p+:8], latchPad[8*p+:8]};
      wire [31:0] pinWord = {24'h000000, pinPad[8*p+:8]};
      assign wrCtrl[p] = wrFire && awAddrQ == CO;
      assign rdCtrl[p] = araddr == CO;
      assign rdPin[p] = araddr == PO;
      assign rdAcc[p+1] = rdAcc[p] | ({32{rdCtrl[p]}} & ctrlWord) | ({32{rdPin[p]}} & pinWord);
    end
  endgenerate

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : gPin
      wire [1:0] modeReq = {cfg1[i], cfg2[i]};
      wire [1:0] mode;
      // serial pins keep bit one set
      if (i == pcei_pkg::RST_PIN) begin : gRst
        assign mode = pcei_pkg::MODE_INPUT;
      end else if (i == pcei_pkg::SCL_PIN || i == pcei_pkg::SDA_PIN) begin : gSer
        assign mode = {1'b1, cfg2[i]};
      end else begin : gFree
        assign mode = modeReq;
      end
      wire isQuasi = mode == pcei_pkg::MODE_QUASI;
      wire isPush = mode == pcei_pkg::MODE_PUSH;
      wire isOd = mode == pcei_pkg::MODE_OD;
      // open drain pulls low on zero only
      // quasi releases a one to the weak pull-up
      assign next_pad[i].oeN = !(isPush || ((isQuasi || isOd) && !latch[i]));
      assign next_pad[i].out = isPush && latch[i];
      assign next_pad[i].weakUp = isQuasi && latch[i];
    end
  endgenerate

  genvar k;
  generate
    for (k = 0; k < 2; k++) begin : gInt
      localparam int PIN = (k == 0) ? pcei_pkg::INT0_PIN : pcei_pkg::INT1_PIN;
      localparam int FB = (k == 0) ? pcei_pkg::TIC_FLAG0 : pcei_pkg::TIC_FLAG1;
      wire swWr = wrTic && wStrbQ[0];
      // high then low sample is a falling edge
      wire fallEdge = intPrev[k] && !intLvl[k];
      wire setF = fallEdge || (swWr && wDataQ[FB]);
      wire clrF = intAck[k] || (swWr && !wDataQ[FB]);
      assign intLvl[k] = syncB[PIN];
      // trigger select picks edge or level
      // level mode tracks a low pin
      assign next_flag[k] = trig[k] ? (setF || (flag[k] && !clrF)) : !intLvl[k];
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    syncA <= padIn;
    syncB <= syncA;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= pcei_pkg::RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= pcei_pkg::RESP_OKAY;
    end else begin
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awready <= !next_awHeld;
      wready <= !next_wHeld;
      bvalid <= next_bvalid;
      arready <= !next_rvalid;
      rvalid <= next_rvalid;
      if (wrFire) begin
        bresp <= wrHit ? pcei_pkg::RESP_OKAY : pcei_pkg::RESP_SLVERR;
      end
      if (arTake) begin
        rdata <= rdAcc[4];
        rresp <= rdHit ? pcei_pkg::RESP_OKAY : pcei_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (awTake) begin
      awAddrQ <= awaddr;
    end
    if (wTake) begin
      wDataQ <= wdata;
      wStrbQ <= wstrb;
    end
  end

  // reset leaves every pin input only
  always_ff @(posedge core_clk) begin
    if (rst) begin
      latch <= pcei_pkg::RST_LATCH;
      cfg1 <= pcei_pkg::RST_CFG1;
      cfg2 <= pcei_pkg::RST_CFG2;
      adis <= pcei_pkg::RST_ADIS;
      padDrive <= {N{pcei_pkg::PAD_RST}};
    end else begin
      for (int j = 0; j < N; j++) begin
        if (wrCtrl[j / 8] && wStrbQ[0]) latch[j] <= wDataQ[j % 8];
        if (wrCtrl[j / 8] && wStrbQ[1]) cfg1[j] <= wDataQ[8 + j % 8];
        if (wrCtrl[j / 8] && wStrbQ[2]) cfg2[j] <= wDataQ[16 + j % 8];
      end
      if (wrAdis && wStrbQ[0]) adis <= wDataQ[pcei_pkg::ADIS_HI:pcei_pkg::ADIS_LO];
      padDrive <= next_pad;
    end
  end

  // set beats clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      trig <= pcei_pkg::RST_TRIG;
      intEn <= pcei_pkg::RST_IEN;
      globalEn <= 1'b0;
      flag <= 2'h0;
      intPrev <= 2'h3;
      extIntReq <= 2'h0;
      extWake <= 1'b0;
    end else begin
      if (wrTic && wStrbQ[0]) trig <= {wDataQ[pcei_pkg::TIC_TRIG1], wDataQ[pcei_pkg::TIC_TRIG0]};
      if (wrIen && wStrbQ[0]) begin
        intEn <= {wDataQ[pcei_pkg::IEN_EXT1], wDataQ[pcei_pkg::IEN_EXT0]};
        globalEn <= wDataQ[pcei_pkg::IEN_GLOBAL];
      end
      flag <= next_flag;
      intPrev <= intLvl;
      // source enable and global mask gate
      extIntReq <= flag & intEn & {2{globalEn}};
      extWake <= (cpuIdle || cpuPowerDown) && (|(flag & intEn));
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_edge_sets_flag: assert property (trig[0] && intPrev[0] && !intLvl[0] |=> flag[0])
    else $error("falling edge did not set flag 0");
  a_level_follows: assert property (!trig[0] ##1 !trig[0] |-> flag[0] == !$past(intLvl[0]))
    else $error("level flag not tracking pin");
  a_edge_holds: assert property (trig[0] && flag[0] && !intAck[0] && !wrTic ##1 trig[0] |-> flag[0])
    else $error("edge flag dropped without clear");
  a_req_gated: assert property (extIntReq[0] |-> $past(flag[0] && intEn[0] && globalEn))
    else $error("request without enable");
  a_wake_cause: assert property (extWake |-> $past((cpuIdle || cpuPowerDown) && |(flag & intEn)))
    else $error("wake without enabled request");
  a_rst_pin_in: assert property (padDrive[pcei_pkg::RST_PIN].oeN && !padDrive[pcei_pkg::RST_PIN].weakUp)
    else $error("reset pin driven");
  a_serial_od: assert property (!padDrive[pcei_pkg::SCL_PIN].out && !padDrive[pcei_pkg::SCL_PIN].weakUp &&
                                !padDrive[pcei_pkg::SDA_PIN].out && !padDrive[pcei_pkg::SDA_PIN].weakUp)
    else $error("serial pin driven high");
  a_input_hiz: assert property ($past(cfg1[16] && !cfg2[16]) |-> padDrive[16].oeN && !padDrive[16].weakUp)
    else $error("input-only pin driven");
  a_quasi_weak: assert property ($past(!cfg1[16] && !cfg2[16]) |-> padDrive[16].oeN == $past(latch[16]))
    else $error("quasi drive wrong");
  a_push_high: assert property ($past(!cfg1[16] && cfg2[16] && latch[16]) |->
                                !padDrive[16].oeN && padDrive[16].out)
    else $error("push-pull not high");
  a_analog_cut: assert property (arvalid && arready && araddr == pcei_pkg::OFF_PIN0 && adis[1] |=> !rdata[1])
    else $error("disabled input visible");

  c_edge_irq: cover property (trig[0] && intEn[0] && globalEn ##[1:4] extIntReq[0]);
  c_wake: cover property (cpuPowerDown ##1 extWake);
  c_write_read: cover property (bvalid && bready ##[1:8] rvalid && rready);
endmodule

// ==== pcei_pkg.sv ====
package pcei_pkg;
  localparam int NPINS = 26;
  localparam int NPORTS = 4;
  localparam int AW = 8;
  localparam int RST_PIN = 13;
  localparam int SCL_PIN = 10;
  localparam int SDA_PIN = 11;
  localparam int INT0_PIN = 11;
  localparam int INT1_PIN = 12;
  localparam logic [1:0] MODE_QUASI = 2'h0;
  localparam logic [1:0] MODE_PUSH = 2'h1;
  localparam logic [1:0] MODE_INPUT = 2'h2;
  localparam logic [1:0] MODE_OD = 2'h3;
  localparam logic [AW-1:0] OFF_CTRL0 = 8'h00;
  localparam logic [AW-1:0] OFF_PIN0 = 8'h10;
  localparam logic [AW-1:0] OFF_TICTL = 8'h20;
  localparam logic [AW-1:0] OFF_IEN = 8'h24;
  localparam logic [AW-1:0] OFF_ADIS = 8'h28;
  localparam int TIC_TRIG0 = 0;
  localparam int TIC_FLAG0 = 1;
  localparam int TIC_TRIG1 = 2;
  localparam int TIC_FLAG1 = 3;
  localparam int IEN_EXT0 = 0;
  localparam int IEN_EXT1 = 2;
  localparam int IEN_GLOBAL = 7;
  localparam int ADIS_LO = 1;
  localparam int ADIS_HI = 5;
  localparam logic [NPINS-1:0] RST_LATCH = 26'h3FFFFFF;
  localparam logic [NPINS-1:0] RST_CFG1 = 26'h3FFFFFF;
  localparam logic [NPINS-1:0] RST_CFG2 = 26'h0000000;
  localparam logic [1:0] RST_TRIG = 2'h0;
  localparam logic [1:0] RST_IEN = 2'h0;
  localparam logic [ADIS_HI:ADIS_LO] RST_ADIS = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic oeN;
    logic out;
    logic weakUp;
  } pcei_pad_t;
  localparam pcei_pad_t PAD_RST = '{oeN: 1'b1, out: 1'b0, weakUp: 1'b0};
endpackage

// ==== pcei_pad_model.sv ====
`timescale 1ns/100ps
module pcei_pad_model (
  input  wire pcei_pkg::pcei_pad_t [25:0] padDrive,
  input  wire logic [25:0]               extEn,
  input  wire logic [25:0]               extVal,
  output logic [25:0]                    padIn
);
  always_comb begin
    for (int i = 0; i < 26; i++) begin
      if (!padDrive[i].oeN) begin
        padIn[i] = padDrive[i].out;
      end else if (extEn[i]) begin
        padIn[i] = extVal[i];
      end else begin
        padIn[i] = 1'b1;
      end
    end
  end
endmodule

// ==== tb.sv ====
`timescale 1ns/100ps
module tb;
  logic                   core_clk = 0;
  logic                   rst = 1;
  logic [7:0]             awaddr = 0;
  logic [7:0]             araddr = 0;
  logic [31:0]            wdata = 0;
  logic [3:0]             wstrb = 0;
  logic                   awvalid = 0;
  logic                   wvalid = 0;
  logic                   arvalid = 0;
  logic                   bready = 1;
  logic                   rready = 1;
  logic                   cpuIdle = 0;
  logic                   cpuPowerDown = 0;
  logic [1:0]             intAck = 0;
  logic [25:0]            extEn = 0;
  logic [25:0]            extVal = 0;
  logic                   awready, wready, bvalid, arready, rvalid, extWake;
  logic [1:0]             bresp, rresp, extIntReq;
  logic [31:0]            rdata;
  logic [25:0]            padIn;
  pcei_pkg::pcei_pad_t [25:0] padDrive;
  int                     errTotal = 0;
  int                     nTests = 0;
  int                     cycles = 0;

  always #25 core_clk = ~core_clk;

  pcei_top dut (.core_clk(core_clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .padIn(padIn), .padDrive(padDrive), .cpuIdle(cpuIdle),
    .cpuPowerDown(cpuPowerDown), .intAck(intAck), .extIntReq(extIntReq), .extWake(extWake));
  pcei_pad_model pads (.padDrive(padDrive), .extEn(extEn), .extVal(extVal), .padIn(padIn));

  task automatic testDone;
    $display("comparisons %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // hang guard, run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errTotal++;
      testDone;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      errTotal++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // released pads: out is meaningless, strong drive: weakUp is
  task automatic chkPad(input int p, input logic o, input logic v, input logic w);
    chk($sformatf("pad%0d", p), {o, o ? w : v}, {padDrive[p].oeN, o ? padDrive[p].weakUp : padDrive[p].out});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad;
    logic wd;
    ad = 0;
    wd = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1;
    wvalid <= 1;
    do begin
      @(posedge core_clk);
      ad = ad | awready;
      wd = wd | wready;
      awvalid <= !ad;
      wvalid <= !wd;
    end while (!(ad && wd));
    do @(posedge core_clk); while (bvalid !== 1'b1);
    chk("bresp", er, bresp);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge core_clk); while (rvalid !== 1'b1);
    chk("rdata", e, rdata);
    chk("rresp", er, rresp);
  endtask

  task automatic tReset;
    rd(8'h00, 32'h0000FFFF, 0);
    rd(8'h28, 0, 0);
    for (int p = 0; p < 26; p++) chkPad(p, 1, 0, 0);
  endtask

  task automatic tModes;
    logic [1:0] m;
    for (int i = 0; i < 8; i++) begin
      m = i[2:1];
      wr(8'h08, {8'h00, {8{m[0]}}, {8{m[1]}}, {8{i[0]}}}, 0);
      tick(2);
      chkPad(16, m == 2'h2 || (i[0] && m != 2'h1), i[0], m == 2'h0 && i[0]);
    end
  endtask

  task automatic tRestrict;
    wr(8'h04, 32'h00FF00FF, 0);
    tick(2);
    chkPad(9, 0, 1, 0);
    chkPad(10, 1, 1, 0);
    chkPad(11, 1, 1, 0);
    chkPad(13, 1, 0, 0);
    wr(8'h04, 32'h000000FF, 0);
    tick(2);
    chkPad(9, 1, 0, 1);
    chkPad(10, 1, 0, 0);
    chkPad(13, 1, 0, 0);
    wr(8'h04, 32'h0000FFFF, 0);
    wr(8'h0C, 32'hFFFFFFFF, 0);
    rd(8'h0C, 32'h00030303, 0);
  endtask

  task automatic tIntEdge;
    wr(8'h20, 1, 0);
    wr(8'h24, 32'h81, 0);
    extEn[11] <= 1;
    extVal[11] <= 0;
    tick(6);
    chk("req", 1, extIntReq);
    rd(8'h20, 3, 0);
    cpuIdle <= 1;
    tick(3);
    chk("wake", 1, extWake);
    cpuIdle <= 0;
    cpuPowerDown <= 1;
    tick(3);
    chk("wake", 1, extWake);
    cpuPowerDown <= 0;
    intAck <= 2'h1;
    tick(1);
    intAck <= 0;
    tick(3);
    // pin still low: no new fall, flag stays clear
    chk("req", 0, extIntReq);
    chk("wake", 0, extWake);
    extEn[11] <= 0;
  endtask

  task automatic tIntLevel;
    wr(8'h24, 32'h04, 0);
    extEn[12] <= 1;
    extVal[12] <= 0;
    tick(6);
    chk("req", 0, extIntReq);
    wr(8'h24, 32'h84, 0);
    tick(3);
    chk("req", 2, extIntReq);
    extEn[12] <= 0;
    tick(6);
    chk("req", 0, extIntReq);
  endtask

  task automatic tAnalog;
    wr(8'h28, 32'hFF, 0);
    rd(8'h28, 32'h3E, 0);
    rd(8'h10, 32'hC1, 0);
    wr(8'h40, 1, 2'h2);
    rd(8'h40, 0, 2'h2);
    rst <= 1;
    tick(2);
    rst <= 0;
    tick(2);
    rd(8'h28, 0, 0);
    rd(8'h10, 32'hFF, 0);
  endtask

  initial begin
    tick(20);
    rst <= 0;
    tick(2);
    tReset;
    tModes;
    tRestrict;
    tIntEdge;
    tIntLevel;
    tAnalog;
    testDone;
  end
endmodule
